// ===== flash_lock_fuse_protection.sv
/*
 * lock bytes, user fuses and access gating of the programming path,
 * reached over a classic wishbone slave.
 * assumes one synchronous clock; code and data flash live outside and
 * act on cmd_accept_o together with the permission outputs.
 */
`timescale 1ns/10ps
// Contract
// - three lock bytes at 00h-02h, each FFh or 00h
// - only chip erase returns lock bytes to FFh
// - level 2 or higher refuses all external programming except lock byte writes and chip erase
// - level 3 or higher blocks external code/data reads, not fuses/signature
// - level never blocks application data flash or application programming; external data writes stop at level 2
// - level decoded from lock bytes: 1, 2, 3 or 4
// - ten user fuses, one per address, default FFh
// - writing 00h clears a fuse, FFh keeps it
// - fuses 00h/01h select the system clock source
// - fuses 02h/03h select start-up timeout, depending on clock kind
// - fuse 04h selects 12-clock or single-cycle timing
// - fuse 05h allows programming entry always or only at power-on
// - external signature write/erase only while signature fuse enabled
// - fuse 07h selects tristate or quasi-bidirectional port start
// - fuse 08h enables application programming
// - fuse 09h connects the crystal input resistor
// - clock select change applies only after next power-on reset
// - entry fuse change applies only when the session ends or at the next power-on reset
// - signature is 256 bytes; chip erase clears page 0 if enabled
// - application writes signature at 0100h-01FFh when its fuse enabled, reads it there always
module flash_lock_fuse_protection #(
	parameter int CYC_512_US = flash_prot_pkg::T_512_US *
		flash_prot_pkg::CLK_MHZ,
	parameter int CYC_1_MS = flash_prot_pkg::T_1_MS_US *
		flash_prot_pkg::CLK_MHZ,
	parameter int CYC_2_MS = flash_prot_pkg::T_2_MS_US *
		flash_prot_pkg::CLK_MHZ,
	parameter int CYC_4_MS = flash_prot_pkg::T_4_MS_US *
		flash_prot_pkg::CLK_MHZ,
	parameter int CYC_16_MS = flash_prot_pkg::T_16_MS_US *
		flash_prot_pkg::CLK_MHZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input flash_prot_pkg::wb_req_t wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output flash_prot_pkg::level_t level_o,
	output logic ext_program_ok_o,
	output logic ext_read_ok_o,
	output logic ext_exec_high_ok_o,
	output flash_prot_pkg::clk_src_t clock_source_o,
	output logic [23:0] startup_cycles_o,
	output logic compat_12clk_o,
	output logic isp_entry_ok_o,
	output logic ports_tristate_o,
	output logic iap_enable_o,
	output logic crystal_oscillator_resistor_o,
	output logic session_o,
	output logic cmd_accept_o
);
	typedef struct packed {
		logic [2:0][7:0] lock;
		logic [9:0][7:0] fuse;
		flash_prot_pkg::clk_src_t clk_applied;
		logic [7:0] isp_applied;
		logic session;
		logic por_window;
		logic refused;
		logic [8:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic ack;
		logic [31:0] dat;
		flash_prot_pkg::level_t level;
		logic prog_ok;
		logic read_ok;
		logic exec_ok;
		logic accept;
		logic exec;
		flash_prot_pkg::op_t last_op;
		logic last_ext;
		flash_prot_pkg::level_t last_lvl;
		logic [7:0] last_wdata;
		logic [3:0] last_fidx;
		logic por_q;
		logic sess_end_q;
	} prot_state_t;

	prot_state_t s_reg;
	prot_state_t s_next;
	flash_prot_pkg::sig_req_t sig_req;
	logic [7:0] sig_rdata;
	logic hit;
	logic wr;
	logic set_ref;
	logic clr_ref;
	logic deny;
	logic ext;
	logic wlock;
	logic sig_fuse_on;
	logic iap_fuse_on;
	logic [3:0] fidx;
	logic [1:0] lidx;
	flash_prot_pkg::op_t op;

	user_sig_array sig_u (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(sig_req),
		.rd_addr_i(s_reg.addr[7:0]),
		.rd_data_o(sig_rdata)
	);

	startup_timeout_select #(
		.CYC_512_US(CYC_512_US),
		.CYC_1_MS(CYC_1_MS),
		.CYC_2_MS(CYC_2_MS),
		.CYC_4_MS(CYC_4_MS),
		.CYC_16_MS(CYC_16_MS)
	) sut_u (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_i(s_reg.clk_applied),
		.code_i({~flash_prot_pkg::is_prog(s_reg.fuse[flash_prot_pkg::FUSE_SUT1]),
			~flash_prot_pkg::is_prog(s_reg.fuse[flash_prot_pkg::FUSE_SUT0])}),
		.cycles_o(startup_cycles_o)
	);

	// ==========================================================
	// next state
	always_comb
	begin
		s_next = s_reg;
		sig_req = '0;
		set_ref = 1'b0;
		clr_ref = 1'b0;
		deny = 1'b0;
		hit = wb_req_i.cyc && wb_req_i.stb && !s_reg.ack;
		wr = hit && wb_req_i.we;
		op = flash_prot_pkg::op_t'(wb_req_i.dat[3:0]);
		ext = !wb_req_i.dat[flash_prot_pkg::CMD_SRC_BIT];
		fidx = s_reg.addr[3:0];
		lidx = s_reg.addr[1:0];
		wlock = s_reg.level >= flash_prot_pkg::LEVEL_2;
		sig_fuse_on = flash_prot_pkg::is_prog(
			s_reg.fuse[flash_prot_pkg::FUSE_SIGPROG]);
		iap_fuse_on = flash_prot_pkg::is_prog(
			s_reg.fuse[flash_prot_pkg::FUSE_IAP]);
		s_next.ack = hit;
		s_next.exec = 1'b0;
		s_next.por_q = 1'b0;
		s_next.sess_end_q = 1'b0;
		if (hit && !wb_req_i.we)
		begin
			case (wb_req_i.adr)
				flash_prot_pkg::ADR_ADDR: s_next.dat = {23'h0, s_reg.addr};
				flash_prot_pkg::ADR_WDATA: s_next.dat = {24'h0, s_reg.wdata};
				flash_prot_pkg::ADR_RDATA: s_next.dat = {24'h0, s_reg.rdata};
				flash_prot_pkg::ADR_STATUS: s_next.dat = {24'h0,
					s_reg.clk_applied, s_reg.por_window, s_reg.refused,
					s_reg.session, s_reg.level};
				default: s_next.dat = 32'h0;
			endcase
		end
		if (wr && wb_req_i.sel[0])
		begin
			case (wb_req_i.adr)
				flash_prot_pkg::ADR_ADDR: s_next.addr[7:0] = wb_req_i.dat[7:0];
				flash_prot_pkg::ADR_WDATA: s_next.wdata = wb_req_i.dat[7:0];
				flash_prot_pkg::ADR_STATUS:
					clr_ref = wb_req_i.dat[flash_prot_pkg::STAT_REFUSED_BIT];
				flash_prot_pkg::ADR_CONTROL:
				begin
					if (wb_req_i.dat[flash_prot_pkg::CTRL_POR_BIT])
					begin
						// power-on reset latches the clock and entry fuses
						s_next.clk_applied = flash_prot_pkg::clk_src_t'({
							flash_prot_pkg::is_prog(s_reg.fuse[flash_prot_pkg::FUSE_CS1]),
							flash_prot_pkg::is_prog(s_reg.fuse[flash_prot_pkg::FUSE_CS0])
						});
						s_next.isp_applied = s_reg.fuse[flash_prot_pkg::FUSE_ISP];
						s_next.por_window = 1'b1;
						s_next.session = 1'b0;
						s_next.por_q = 1'b1;
					end
					else if (wb_req_i.dat[flash_prot_pkg::CTRL_SESSION_BIT])
					begin
						if (!s_reg.session && s_reg.isp_applied !=
							flash_prot_pkg::BYTE_ERASED && !s_reg.por_window)
							set_ref = 1'b1;
						else if (!s_reg.session)
						begin
							s_next.session = 1'b1;
							s_next.por_window = 1'b0;
						end
					end
					else if (s_reg.session)
					begin
						s_next.session = 1'b0;
						s_next.isp_applied = s_reg.fuse[flash_prot_pkg::FUSE_ISP];
						s_next.sess_end_q = 1'b1;
					end
				end
				flash_prot_pkg::ADR_CMD:
				begin
					s_next.exec = 1'b1;
					if (ext && !s_reg.session)
						deny = 1'b1;
					else
					begin
						case (op)
							flash_prot_pkg::OP_WR_LOCK:
								if (!ext || s_reg.addr > 9'(flash_prot_pkg::LOCK_LAST))
									deny = 1'b1;
								else if (flash_prot_pkg::is_prog(s_reg.wdata))
									s_next.lock[lidx] = flash_prot_pkg::BYTE_PROG;
							flash_prot_pkg::OP_WR_FUSE:
								if (!ext || wlock ||
									s_reg.addr > 9'(flash_prot_pkg::FUSE_LAST))
									deny = 1'b1;
								else if (flash_prot_pkg::is_prog(s_reg.wdata))
									s_next.fuse[fidx] = flash_prot_pkg::BYTE_PROG;
							flash_prot_pkg::OP_WR_FUSE_AE:
								if (!ext || wlock ||
									s_reg.addr > 9'(flash_prot_pkg::FUSE_LAST))
									deny = 1'b1;
								else
								begin
									s_next.fuse = {10{flash_prot_pkg::BYTE_ERASED}};
									s_next.fuse[fidx] = flash_prot_pkg::is_prog(
										s_reg.wdata) ? flash_prot_pkg::BYTE_PROG :
										flash_prot_pkg::BYTE_ERASED;
								end
							flash_prot_pkg::OP_WR_SIG:
								if (ext ? (wlock || !sig_fuse_on) :
									(!iap_fuse_on || !s_reg.addr[8]))
									deny = 1'b1;
								else
								begin
									sig_req.we = 1'b1;
									sig_req.addr = s_reg.addr[7:0];
									sig_req.data = s_reg.wdata;
								end
							flash_prot_pkg::OP_ERASE_SIG:
								if (!ext || wlock || !sig_fuse_on)
									deny = 1'b1;
								else
								begin
									sig_req.erase = 1'b1;
									sig_req.page = s_reg.addr[7];
								end
							flash_prot_pkg::OP_CHIP_ERASE:
								if (!ext)
									deny = 1'b1;
								else
								begin
									s_next.lock = {3{flash_prot_pkg::BYTE_ERASED}};
									sig_req.erase = sig_fuse_on;
									sig_req.page = 1'b0;
								end
							flash_prot_pkg::OP_RD_LOCK:
								if (s_reg.addr > 9'(flash_prot_pkg::LOCK_LAST))
									deny = 1'b1;
								else
									s_next.rdata = s_reg.lock[lidx];
							flash_prot_pkg::OP_RD_FUSE:
								if (s_reg.addr > 9'(flash_prot_pkg::FUSE_LAST))
									deny = 1'b1;
								else
									s_next.rdata = s_reg.fuse[fidx];
							flash_prot_pkg::OP_RD_SIG:
								if (!ext && !s_reg.addr[8])
									deny = 1'b1;
								else
									s_next.rdata = sig_rdata;
							flash_prot_pkg::OP_WR_CODE:
								deny = ext ? wlock : !iap_fuse_on;
							flash_prot_pkg::OP_RD_CODE:
								deny = ext && !s_reg.read_ok;
							flash_prot_pkg::OP_WR_DATA:
								deny = ext && wlock;
							default: deny = 1'b1;
						endcase
					end
					set_ref = deny;
					s_next.last_op = op;
					s_next.last_ext = ext;
					s_next.last_lvl = s_reg.level;
					s_next.last_wdata = s_reg.wdata;
					s_next.last_fidx = fidx;
				end
				default: ;
			endcase
		end
		if (wr && wb_req_i.sel[1] && wb_req_i.adr == flash_prot_pkg::ADR_ADDR)
			s_next.addr[8] = wb_req_i.dat[8];
		s_next.accept = s_next.exec && !deny;
		// a refusal in the clearing cycle stays visible
		s_next.refused = (s_reg.refused && !clr_ref) || set_ref;
		s_next.level = flash_prot_pkg::level_of({
			flash_prot_pkg::is_prog(s_next.lock[2]),
			flash_prot_pkg::is_prog(s_next.lock[1]),
			flash_prot_pkg::is_prog(s_next.lock[0])});
		s_next.prog_ok = s_next.session &&
			s_next.level == flash_prot_pkg::LEVEL_1;
		s_next.read_ok = s_next.level < flash_prot_pkg::LEVEL_3;
		s_next.exec_ok = s_next.level < flash_prot_pkg::LEVEL_4;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_reg <= '0;
			s_reg.lock <= {3{flash_prot_pkg::BYTE_ERASED}};
			s_reg.fuse <= {10{flash_prot_pkg::BYTE_ERASED}};
			s_reg.isp_applied <= flash_prot_pkg::BYTE_ERASED;
			s_reg.clk_applied <= flash_prot_pkg::CLK_HS_CRYSTAL_OSCILLATOR;
			s_reg.por_window <= 1'b1;
			s_reg.level <= flash_prot_pkg::LEVEL_1;
			s_reg.last_lvl <= flash_prot_pkg::LEVEL_1;
			s_reg.read_ok <= 1'b1;
			s_reg.exec_ok <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// ==========================================================
	// outputs, all from flops
	assign wb_dat_o = s_reg.dat;
	assign wb_ack_o = s_reg.ack;
	assign level_o = s_reg.level;
	assign ext_program_ok_o = s_reg.prog_ok;
	assign ext_read_ok_o = s_reg.read_ok;
	assign ext_exec_high_ok_o = s_reg.exec_ok;
	assign clock_source_o = s_reg.clk_applied;
	assign compat_12clk_o = !flash_prot_pkg::is_prog(
		s_reg.fuse[flash_prot_pkg::FUSE_COMPAT]);
	assign isp_entry_ok_o = s_reg.por_window ||
		s_reg.isp_applied == flash_prot_pkg::BYTE_ERASED;
	assign ports_tristate_o = !flash_prot_pkg::is_prog(
		s_reg.fuse[flash_prot_pkg::FUSE_TRISTATE]);
	assign iap_enable_o = flash_prot_pkg::is_prog(
		s_reg.fuse[flash_prot_pkg::FUSE_IAP]);
	assign crystal_oscillator_resistor_o = flash_prot_pkg::is_prog(
		s_reg.fuse[flash_prot_pkg::FUSE_XRES]);
	assign session_o = s_reg.session;
	assign cmd_accept_o = s_reg.accept;

	// ==========================================================
	// checks
	sequence ext_fuse_keep_s;
		s_reg.accept && s_reg.last_ext &&
			s_reg.last_op == flash_prot_pkg::OP_WR_FUSE &&
			s_reg.last_wdata == flash_prot_pkg::BYTE_ERASED;
	endsequence

	ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	lock_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_reg.lock[0] != $past(s_reg.lock[0]) &&
			s_reg.lock[0] == flash_prot_pkg::BYTE_ERASED) |->
		(s_reg.accept && s_reg.last_op == flash_prot_pkg::OP_CHIP_ERASE))
		else $error("lock byte erased without chip erase");

	level_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		level_o == flash_prot_pkg::level_of({s_reg.lock[2] == 8'h00,
			s_reg.lock[1] == 8'h00, s_reg.lock[0] == 8'h00}))
		else $error("level does not match lock bytes");

	prog_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_reg.accept && s_reg.last_ext &&
			(s_reg.last_op == flash_prot_pkg::OP_WR_FUSE ||
			s_reg.last_op == flash_prot_pkg::OP_WR_SIG ||
			s_reg.last_op == flash_prot_pkg::OP_WR_CODE)) |->
		s_reg.last_lvl == flash_prot_pkg::LEVEL_1)
		else $error("external programming accepted while locked");

	read_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_reg.accept && s_reg.last_ext &&
			s_reg.last_op == flash_prot_pkg::OP_RD_CODE) |->
		s_reg.last_lvl < flash_prot_pkg::LEVEL_3)
		else $error("code read accepted at level 3 or above");

	app_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_reg.exec && !s_reg.last_ext &&
			s_reg.last_op == flash_prot_pkg::OP_WR_DATA) |-> s_reg.accept)
		else $error("application data write refused");

	clk_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(clock_source_o) |-> s_reg.por_q)
		else $error("clock source changed without power-on");

	isp_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(s_reg.isp_applied) |-> (s_reg.por_q || s_reg.sess_end_q))
		else $error("entry fuse applied mid-session");

	fuse_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_fuse_keep_s |-> s_reg.fuse == $past(s_reg.fuse))
		else $error("writing FFh changed a fuse");

endmodule

// ===== flash_lock_fuse_protection_tb_top.sv
/* self-checking bench of the lock and fuse block.
   assumes short start-up counts; the model drives the bus. */
`timescale 1ns/10ps
module flash_lock_fuse_protection_tb_top;
	// ==========================================
	// signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	flash_prot_pkg::wb_req_t req;
	flash_prot_pkg::level_t level;
	flash_prot_pkg::clk_src_t clk_src;
	logic [31:0] wb_dat_o;
	logic [23:0] su_cycles;
	logic wb_ack_o, program_ok, read_ok, exec_ok, compat, entry_ok;
	logic tristate, iap_en, xres, session, accept;
	logic [31:0] exp_q[$];
	logic [7:0] a0, a1, d0, d1, d2;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	int accepts = 0;
	int n = 0;
	int seed = 32'h13ac;
	// clock select, timing, entry, signature, application, resistor fuses
	logic [3:0] n_list[6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
	initial forever #2 clk_i = ~clk_i;
	flash_lock_fuse_protection #(.CYC_1_MS(20), .CYC_4_MS(40),
		.CYC_16_MS(50))
		flash_lock_fuse_protection_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.level_o(level), .ext_program_ok_o(program_ok),
		.ext_read_ok_o(read_ok), .ext_exec_high_ok_o(exec_ok),
		.clock_source_o(clk_src), .startup_cycles_o(su_cycles),
		.compat_12clk_o(compat), .isp_entry_ok_o(entry_ok),
		.ports_tristate_o(tristate), .iap_enable_o(iap_en),
		.crystal_oscillator_resistor_o(xres), .session_o(session),
		.cmd_accept_o(accept));
	isp_programmer_model isp_programmer_model_inst (.clk_i(clk_i),
		.wb_ack_i(wb_ack_o), .req_o(req));
	// ==========================================
	// checking
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_rd(input logic [31:0] got);
		cmp_out(got, exp_q.size() > 0 ? exp_q.pop_front() : ~got);
	endtask
	// read data is judged at the edge the master takes it
	always @(posedge clk_i)
	begin
		cycles++;
		if (wb_ack_o === 1'b1 && req.cyc === 1'b1 && req.we === 1'b0)
			cmp_rd(wb_dat_o);
		if (accept === 1'b1)
			accepts++;
		if (cycles == 20000)
		begin
			fails++;
			end_of_test();
		end
	end
	// ==========================================
	// stimulus helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		isp_programmer_model_inst.xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		exp_q.push_back(exp);
		isp_programmer_model_inst.xfer(1'b0, a, 32'h0);
	endtask
	task automatic op(input logic src, input logic [3:0] code,
		input logic [8:0] adr, input logic [7:0] d);
		wr(flash_prot_pkg::ADR_ADDR, 32'(adr));
		wr(flash_prot_pkg::ADR_WDATA, 32'(d));
		wr(flash_prot_pkg::ADR_CMD, 32'({src, code}));
	endtask
	task automatic rd_nv(input logic [3:0] code, input logic [8:0] adr,
		input logic [7:0] exp);
		op(1'b0, code, adr, 8'h00);
		rd(flash_prot_pkg::ADR_RDATA, 32'(exp));
	endtask
	// outputs are registered, so let two edges pass before looking
	task automatic chk(input logic [13:0] exp);
		repeat (2) @(posedge clk_i);
		#1 cmp_out(32'({level, program_ok, read_ok, exec_ok, clk_src,
			compat, entry_ok, tristate, iap_en, xres, session}), 32'(exp));
		@(posedge clk_i);
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		a0 = {1'b0, 7'($random(seed))};
		a1 = {1'b1, 7'($random(seed))};
		// never blank or zero, and d0 differs from d1 and d2, so a lost write or erase shows
		d0 = {2'b10, 6'($random(seed))};
		d1 = {2'b01, 6'($random(seed))};
		d2 = ~d0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({3'h1, 3'b011, 2'h0, 6'b111000});
		wr(flash_prot_pkg::ADR_CONTROL, 32'h2);
		chk({3'h1, 3'b111, 2'h0, 6'b111001});
		// external lock reads are accepted once a session is open
		rd_nv(flash_prot_pkg::OP_RD_LOCK, 9'h002, 8'hFF);
		// fuses come before any lock is raised
		foreach (n_list[i])
			op(1'b0, flash_prot_pkg::OP_WR_FUSE, 9'(n_list[i]),
				isp_programmer_model_inst.nv_byte(1'b1));
		op(1'b0, flash_prot_pkg::OP_WR_FUSE, 9'h006, 8'hFF);
		rd_nv(flash_prot_pkg::OP_RD_FUSE, 9'h006, 8'h00);
		chk({3'h1, 3'b111, 2'h0, 6'b011111});
		wr(flash_prot_pkg::ADR_CONTROL, 32'h0);
		chk({3'h1, 3'b011, 2'h0, 6'b001110});
		wr(flash_prot_pkg::ADR_CONTROL, 32'h1);
		chk({3'h1, 3'b011, 2'h1, 6'b011110});
		cmp_out(32'(su_cycles), 32'd50);
		wr(flash_prot_pkg::ADR_CONTROL, 32'h2);
		chk({3'h1, 3'b111, 2'h1, 6'b001111});
		op(1'b0, flash_prot_pkg::OP_WR_SIG, 9'(a0), d0);
		op(1'b0, flash_prot_pkg::OP_WR_SIG, 9'(a1), d1);
		rd_nv(flash_prot_pkg::OP_RD_SIG, 9'(a1), d1);
		op(1'b0, flash_prot_pkg::OP_WR_LOCK, 9'h000, 8'h00);
		chk({3'h2, 3'b011, 2'h1, 6'b001111});
		op(1'b0, flash_prot_pkg::OP_WR_FUSE, 9'h007, 8'h00);
		rd(flash_prot_pkg::ADR_STATUS, 32'h5A);
		rd_nv(flash_prot_pkg::OP_RD_FUSE, 9'h007, 8'hFF);
		wr(flash_prot_pkg::ADR_STATUS, 32'h10);
		op(1'b0, flash_prot_pkg::OP_WR_LOCK, 9'h001, 8'h00);
		chk({3'h3, 3'b001, 2'h1, 6'b001111});
		rd_nv(flash_prot_pkg::OP_RD_SIG, 9'(a0), d0);
		n = accepts;
		op(1'b1, flash_prot_pkg::OP_WR_DATA, 9'h010, d2);
		op(1'b0, flash_prot_pkg::OP_RD_CODE, 9'h010, 8'h00);
		cmp_out(32'(accepts - n), 32'd1);
		op(1'b1, flash_prot_pkg::OP_WR_SIG, {1'b1, a0}, d2);
		rd_nv(flash_prot_pkg::OP_RD_SIG, 9'(a0), d2);
		op(1'b0, flash_prot_pkg::OP_WR_LOCK, 9'h002, 8'h00);
		chk({3'h4, 3'b000, 2'h1, 6'b001111});
		op(1'b0, flash_prot_pkg::OP_CHIP_ERASE, 9'h000, 8'h00);
		chk({3'h1, 3'b111, 2'h1, 6'b001111});
		rd_nv(flash_prot_pkg::OP_RD_SIG, 9'(a0), 8'hFF);
		rd_nv(flash_prot_pkg::OP_RD_SIG, 9'(a1), d1);
		// fuses go back to blank only through a row rewrite
		op(1'b0, flash_prot_pkg::OP_WR_FUSE_AE, 9'h009, 8'hFF);
		chk({3'h1, 3'b111, 2'h1, 6'b101001});
		rd(8'h18, 32'h0);
		end_of_test();
	end
endmodule

// ===== flash_prot_pkg.sv
/*
 * shared constants, types and decode helpers for the flash protection
 * and user fuse block.
 * assumes a 250 MHz system clock and a 32-bit classic wishbone master.
 */
package flash_prot_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ADR_CMD = 8'h00;
	localparam logic [7:0] ADR_ADDR = 8'h04;
	localparam logic [7:0] ADR_WDATA = 8'h08;
	localparam logic [7:0] ADR_RDATA = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	localparam logic [7:0] ADR_CONTROL = 8'h14;

	// ==========================================================
	// field positions
	localparam int CMD_SRC_BIT = 4;
	localparam int STAT_SESSION_BIT = 3;
	localparam int STAT_REFUSED_BIT = 4;
	localparam int STAT_PORWIN_BIT = 5;
	localparam int CTRL_POR_BIT = 0;
	localparam int CTRL_SESSION_BIT = 1;

	// ==========================================================
	// nonvolatile byte values and layout
	localparam logic [7:0] BYTE_PROG = 8'h00;
	localparam logic [7:0] BYTE_ERASED = 8'hFF;
	localparam int LOCK_COUNT = 3;
	localparam int FUSE_COUNT = 10;
	localparam logic [3:0] FUSE_CS0 = 4'h0;
	localparam logic [3:0] FUSE_CS1 = 4'h1;
	localparam logic [3:0] FUSE_SUT0 = 4'h2;
	localparam logic [3:0] FUSE_SUT1 = 4'h3;
	localparam logic [3:0] FUSE_COMPAT = 4'h4;
	localparam logic [3:0] FUSE_ISP = 4'h5;
	localparam logic [3:0] FUSE_SIGPROG = 4'h6;
	localparam logic [3:0] FUSE_TRISTATE = 4'h7;
	localparam logic [3:0] FUSE_IAP = 4'h8;
	localparam logic [3:0] FUSE_XRES = 4'h9;
	localparam logic [1:0] LOCK_LAST = 2'h2;
	localparam logic [3:0] FUSE_LAST = 4'h9;

	// ==========================================================
	// start-up timeouts
	localparam int CLK_MHZ = 250;
	localparam int T_16_US = 16;
	localparam int T_512_US = 512;
	localparam int T_1_MS_US = 1000;
	localparam int T_2_MS_US = 2000;
	localparam int T_4_MS_US = 4000;
	localparam int T_16_MS_US = 16000;
	localparam logic [23:0] CYC_16_US = 24'(T_16_US * CLK_MHZ);

	// ==========================================================
	// types
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_WR_LOCK = 4'h1,
		OP_WR_FUSE = 4'h2,
		OP_WR_FUSE_AE = 4'h3,
		OP_WR_SIG = 4'h4,
		OP_ERASE_SIG = 4'h5,
		OP_CHIP_ERASE = 4'h6,
		OP_RD_LOCK = 4'h7,
		OP_RD_FUSE = 4'h8,
		OP_RD_SIG = 4'h9,
		OP_WR_CODE = 4'hA,
		OP_RD_CODE = 4'hB,
		OP_WR_DATA = 4'hC
	} op_t;

	typedef enum logic [1:0] {
		CLK_HS_CRYSTAL_OSCILLATOR = 2'h0,
		CLK_LS_CRYSTAL_OSCILLATOR = 2'h1,
		CLK_EXT = 2'h2,
		CLK_AUX_OSC = 2'h3
	} clk_src_t;

	typedef enum logic [2:0] {
		LEVEL_1 = 3'h1,
		LEVEL_2 = 3'h2,
		LEVEL_3 = 3'h3,
		LEVEL_4 = 3'h4
	} level_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic we;
		logic erase;
		logic page;
		logic [7:0] addr;
		logic [7:0] data;
	} sig_req_t;

	// ==========================================================
	// helpers
	function automatic logic is_prog(input logic [7:0] b);
		return b == BYTE_PROG;
	endfunction

	// most restrictive level implied by any programmed lock byte
	function automatic level_t level_of(input logic [2:0] prog);
		level_t l;
		l = LEVEL_1;
		if (prog[2])
			l = LEVEL_4;
		else if (prog[1])
			l = LEVEL_3;
		else if (prog[0])
			l = LEVEL_2;
		return l;
	endfunction

endpackage

// ===== isp_programmer_model.sv
/* programmer model: classic wishbone master on the block's bus.
   assumes its tasks are entered right after a rising clock edge. */
`timescale 1ns/10ps
module isp_programmer_model (
	input wire logic clk_i,
	input wire logic wb_ack_i,
	output flash_prot_pkg::wb_req_t req_o
);
	// ==========================================
	// bus cycles
	initial req_o = '0;
	// lock and fuse data is only ever all zero or all one
	function automatic logic [7:0] nv_byte(input logic prog);
		return prog ? flash_prot_pkg::BYTE_PROG : flash_prot_pkg::BYTE_ERASED;
	endfunction
	// request held until ack is sampled, then one idle cycle
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		do
			@(posedge clk_i);
		while (wb_ack_i !== 1'b1);
		req_o <= '0;
		@(posedge clk_i);
	endtask
endmodule

// ===== startup_timeout_select.sv
/*
 * maps clock source and start-up fuses to a wake-up timeout in cycles.
 * assumes the clock source input is the value applied at power-on.
 */
`timescale 1ns/10ps
module startup_timeout_select #(
	parameter int CYC_512_US = 128000,
	parameter int CYC_1_MS = 250000,
	parameter int CYC_2_MS = 500000,
	parameter int CYC_4_MS = 1000000,
	parameter int CYC_16_MS = 4000000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input flash_prot_pkg::clk_src_t src_i,
	input wire logic [1:0] code_i,
	output logic [23:0] cycles_o
);
	typedef struct packed {
		logic [23:0] cycles;
	} sut_state_t;

	sut_state_t s_reg;
	sut_state_t s_next;
	logic crystal_oscillator;

	initial
	begin
		if (CYC_16_MS >= (1 << 24) || CYC_512_US < 1)
			$error("startup timeout counts do not fit 24 bits");
	end

	// ==========================================================
	// table
	always_comb
	begin
		s_next = s_reg;
		crystal_oscillator = (src_i == flash_prot_pkg::CLK_HS_CRYSTAL_OSCILLATOR) ||
			(src_i == flash_prot_pkg::CLK_LS_CRYSTAL_OSCILLATOR);
		case (code_i)
			2'h0: s_next.cycles = crystal_oscillator ? 24'(CYC_1_MS) :
				flash_prot_pkg::CYC_16_US;
			2'h1: s_next.cycles = crystal_oscillator ? 24'(CYC_2_MS) : 24'(CYC_512_US);
			2'h2: s_next.cycles = crystal_oscillator ? 24'(CYC_4_MS) : 24'(CYC_1_MS);
			default: s_next.cycles = crystal_oscillator ? 24'(CYC_16_MS) : 24'(CYC_4_MS);
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign cycles_o = s_reg.cycles;

endmodule

// ===== user_sig_array.sv
/*
 * 256-byte user signature store, two 128-byte pages.
 * assumes the caller has already applied every access gate.
 */
`timescale 1ns/10ps
module user_sig_array (
	input wire logic clk_i,
	input wire logic rst_i,
	input flash_prot_pkg::sig_req_t req_i,
	input wire logic [7:0] rd_addr_i,
	output logic [7:0] rd_data_o
);
	typedef struct packed {
		logic [255:0][7:0] mem;
	} sig_state_t;

	sig_state_t s_reg;
	sig_state_t s_next;

	// ==========================================================
	// update
	always_comb
	begin
		s_next = s_reg;
		if (req_i.erase)
		begin
			for (int i = 0; i < 128; i++)
				s_next.mem[{req_i.page, 7'(i)}] = flash_prot_pkg::BYTE_ERASED;
		end
		else if (req_i.we)
			s_next.mem[req_i.addr] = req_i.data;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s_reg <= {256{flash_prot_pkg::BYTE_ERASED}};
		else
			s_reg <= s_next;
	end

	assign rd_data_o = s_reg.mem[rd_addr_i];

endmodule
